/* verilog/epm_pin_mux.sv */
`timescale 1ns/1ps
// Function
// RL1 - RMII uses two data bits, no clocks
// RL2 - MII uses four bits, collision, bidirectional clocks
// RL3 - GPSI passes one serial bit, collision, clocks
// RL4 - no module: inputs pulled idle, transmit driven
// RL5 - uplink GMII uses eight bits, errors, clocks
// RL6 - uplink MII uses four bits, no errors
// RL7 - uplink always uses mii tx clock, crs, col
// RL8 - uplink offers only GMII and MII
// RL9 - strap pulled up enables module detection
// RL10 - each fast port field steers own pins
// RL11 - unused transmit outputs driven low
module epm_pin_mux
  import epm_pkg::*;
#(
  parameter int NPORTS = epm_pkg::NUM_FAST_PORTS
) (
  input wire logic i_clk_sys, // system clock 125 MHz
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_module_detect_strap, // strap pin, high enables
  input wire logic [NPORTS-1:0] i_module_present, // per fast port
  input wire logic i_uplink_module_present, // uplink presence
  input wire logic [2*NPORTS-1:0] i_fast_port_interface_config, // 2b/port
  input wire logic [1:0] i_uplink_interface_config, // uplink field
  input wire logic [4*NPORTS-1:0] i_fast_rxd, // fast rx data pins
  input wire logic [NPORTS-1:0] i_fast_port_carrier_valid, // crs/dv pins
  input wire logic [NPORTS-1:0] i_fast_col, // fast collision pins
  input wire logic [NPORTS-1:0] i_fast_port_tx_clock, // tx clock pin in
  input wire logic [NPORTS-1:0] i_fast_port_rx_clock, // rx clock pin in
  input wire logic [4*NPORTS-1:0] i_mac_fast_txd, // mac tx data
  input wire logic [NPORTS-1:0] i_mac_fast_txen, // mac tx enable
  input wire logic [NPORTS-1:0] i_mac_fast_tx_clock, // clocks to drive
  input wire logic [NPORTS-1:0] i_mac_fast_rx_clock, // clocks to drive
  input wire logic [NPORTS-1:0] i_mac_fast_clk_drive, // drive clocks
  output logic [4*NPORTS-1:0] o_fast_txd, // fast tx data pins
  output logic [NPORTS-1:0] o_fast_txen, // fast tx enable pins
  output logic [NPORTS-1:0] o_fast_port_tx_clock, // tx clock out
  output logic [NPORTS-1:0] o_fast_port_tx_clock_oe, // tx clock oe
  output logic [NPORTS-1:0] o_fast_port_rx_clock, // rx clock out
  output logic [NPORTS-1:0] o_fast_port_rx_clock_oe, // rx clock oe
  output logic [4*NPORTS-1:0] o_mac_fast_rxd, // rx data to mac
  output logic [NPORTS-1:0] o_mac_fast_crs_dv, // crs/dv to mac
  output logic [NPORTS-1:0] o_mac_fast_col, // collision to mac
  output logic [NPORTS-1:0] o_mac_fast_tx_clock, // tx clock to mac
  output logic [NPORTS-1:0] o_mac_fast_rx_clock, // rx clock to mac
  input wire logic [7:0] i_up_rxd, // uplink rx data pins
  input wire logic i_up_rxdv, // uplink rx valid
  input wire logic i_uplink_rx_error, // uplink rx error pin
  input wire logic i_up_crs, // uplink carrier sense
  input wire logic i_up_col, // uplink collision
  input wire logic i_uplink_rx_clock, // uplink rx clock pin in
  input wire logic i_gigabit_reference_clock, // reference clock pin
  input wire logic i_uplink_mii_tx_clock_in, // mii tx clock pin
  input wire logic [7:0] i_mac_up_txd, // mac uplink tx data
  input wire logic i_mac_up_txen, // mac uplink tx enable
  input wire logic i_mac_up_txer, // mac uplink tx error
  input wire logic i_mac_up_gtx_clock, // mac gmii tx clock
  input wire logic i_mac_up_rx_clock, // mac rx clock to drive
  input wire logic i_mac_up_clk_drive, // drive rx clock in mii
  output logic [7:0] o_up_txd, // uplink tx data pins
  output logic o_up_txen, // uplink tx enable
  output logic o_uplink_tx_error, // uplink tx error pin
  output logic o_uplink_gmii_tx_clock_out, // gmii tx clock pin
  output logic o_uplink_rx_clock, // rx clock out
  output logic o_uplink_rx_clock_oe, // rx clock oe
  output logic [7:0] o_mac_up_rxd, // uplink rx data to mac
  output logic o_mac_up_rxdv, // rx valid to mac
  output logic o_mac_up_rxer, // rx error to mac
  output logic o_mac_up_crs, // crs to mac
  output logic o_mac_up_col, // col to mac
  output logic o_mac_up_rx_clock, // rx clock to mac
  output logic o_mac_up_ref_clock, // reference clock to mac
  output logic o_mac_up_mii_tx_clock, // mii tx clock to mac
  output logic o_detect_enabled, // detection latched after reset
  output logic o_uplink_gmii // uplink in gmii mode
);
  import epm_pkg::*;

  // ******************************
  // strap capture after reset
  // ******************************
  logic [SYNC_STAGES-1:0] strap_sync;
  logic [2:0] settle;
  logic strap_taken;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_sync <= '0;
      settle <= 3'h0;
      strap_taken <= 1'h0;
      o_detect_enabled <= 1'h0;
    end else begin
      strap_sync <= {strap_sync[SYNC_STAGES-2:0], i_module_detect_strap};
      if (!strap_taken) begin
        if (settle == 3'(STRAP_SETTLE_CYCLES)) begin
          if (strap_sync[2] == strap_sync[1]) begin
            o_detect_enabled <= strap_sync[2]; // see RL9
            strap_taken <= 1'h1;
          end
        end else begin
          settle <= settle + 3'h1;
        end
      end
    end
  end

  // ******************************
  // presence inputs synchronised
  // ******************************
  logic [NPORTS:0] pres_s1, pres_s2, pres_s3, pres;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pres_s1 <= '1;
      pres_s2 <= '1;
      pres_s3 <= '1;
      pres <= '1;
    end else begin
      pres_s1 <= {i_uplink_module_present, i_module_present};
      pres_s2 <= pres_s1;
      pres_s3 <= pres_s2;
      pres <= (pres_s2 & pres_s3) | (pres & (pres_s2 | pres_s3));
    end
  end

  // the enable is an argument so that callers re-evaluate when it changes
  function automatic logic absent(input logic en, input logic p);
    absent = en && !p; // see RL9
  endfunction

  // ******************************
  // fast ports
  // ******************************
  for (genvar g = 0; g < NPORTS; g++) begin : g_fast
    epm_fast_port u_port (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_mode(i_fast_port_interface_config[2*g +: 2]), // see RL10
      .i_absent(absent(o_detect_enabled, pres[g])),
      .i_rxd(i_fast_rxd[4*g +: 4]),
      .i_carrier_valid(i_fast_port_carrier_valid[g]),
      .i_col(i_fast_col[g]),
      .i_tx_clock(i_fast_port_tx_clock[g]),
      .i_rx_clock(i_fast_port_rx_clock[g]),
      .i_mac_txd(i_mac_fast_txd[4*g +: 4]),
      .i_mac_txen(i_mac_fast_txen[g]),
      .i_mac_tx_clock(i_mac_fast_tx_clock[g]),
      .i_mac_rx_clock(i_mac_fast_rx_clock[g]),
      .i_mac_clk_drive(i_mac_fast_clk_drive[g]),
      .o_txd(o_fast_txd[4*g +: 4]),
      .o_txen(o_fast_txen[g]),
      .o_tx_clock(o_fast_port_tx_clock[g]),
      .o_tx_clock_oe(o_fast_port_tx_clock_oe[g]),
      .o_rx_clock(o_fast_port_rx_clock[g]),
      .o_rx_clock_oe(o_fast_port_rx_clock_oe[g]),
      .o_mac_rxd(o_mac_fast_rxd[4*g +: 4]),
      .o_mac_crs_dv(o_mac_fast_crs_dv[g]),
      .o_mac_col(o_mac_fast_col[g]),
      .o_mac_tx_clock(o_mac_fast_tx_clock[g]),
      .o_mac_rx_clock(o_mac_fast_rx_clock[g])
    );
  end

  // ******************************
  // uplink mode, only two choices
  // ******************************
  logic up_gmii, up_absent;
  assign up_absent = absent(o_detect_enabled, pres[NPORTS]);
  // any code other than the mii code selects gmii
  assign up_gmii = (i_uplink_interface_config != UPLINK_MODE_MII); // see RL8
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_uplink_gmii <= 1'h1;
    end else begin
      o_uplink_gmii <= up_gmii;
    end
  end

  // ******************************
  // uplink receive
  // ******************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mac_up_rxd <= 8'hff;
      o_mac_up_rxdv <= PULL_UP;
      o_mac_up_rxer <= PULL_UP;
      o_mac_up_crs <= PULL_DOWN;
      o_mac_up_col <= PULL_DOWN;
      o_mac_up_rx_clock <= PULL_UP;
      o_mac_up_ref_clock <= PULL_UP;
      o_mac_up_mii_tx_clock <= PULL_UP;
    end else if (up_absent) begin
      o_mac_up_rxd <= 8'hff; // see RL4
      o_mac_up_rxdv <= PULL_UP;
      o_mac_up_rxer <= PULL_UP;
      o_mac_up_crs <= PULL_DOWN;
      o_mac_up_col <= PULL_DOWN;
      o_mac_up_rx_clock <= PULL_UP;
      o_mac_up_ref_clock <= PULL_UP;
      o_mac_up_mii_tx_clock <= PULL_UP;
    end else begin
      o_mac_up_rxdv <= i_up_rxdv;
      o_mac_up_crs <= i_up_crs; // see RL7
      o_mac_up_col <= i_up_col; // see RL7
      o_mac_up_mii_tx_clock <= i_uplink_mii_tx_clock_in; // see RL7
      o_mac_up_rx_clock <= i_uplink_rx_clock;
      o_mac_up_ref_clock <= i_gigabit_reference_clock; // see RL6
      if (up_gmii) begin
        o_mac_up_rxd <= i_up_rxd; // see RL5
        o_mac_up_rxer <= i_uplink_rx_error; // see RL5
      end else begin
        o_mac_up_rxd <= {4'hf, i_up_rxd[3:0]}; // see RL6
        o_mac_up_rxer <= PULL_DOWN; // see RL6
      end
    end
  end

  // ******************************
  // uplink transmit
  // ******************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_up_txd <= 8'h00;
      o_up_txen <= TX_IDLE;
      o_uplink_tx_error <= TX_IDLE;
      o_uplink_gmii_tx_clock_out <= TX_IDLE;
      o_uplink_rx_clock <= TX_IDLE;
      o_uplink_rx_clock_oe <= 1'h0;
    end else begin
      o_up_txen <= i_mac_up_txen; // see RL7
      o_uplink_rx_clock <= i_mac_up_rx_clock;
      if (up_gmii) begin
        o_up_txd <= i_mac_up_txd; // see RL5
        o_uplink_tx_error <= i_mac_up_txer;
        o_uplink_gmii_tx_clock_out <= i_mac_up_gtx_clock; // see RL5
        o_uplink_rx_clock_oe <= 1'h0;
      end else begin
        o_up_txd <= {4'h0, i_mac_up_txd[3:0]}; // see RL11
        o_uplink_tx_error <= TX_IDLE; // see RL6
        o_uplink_gmii_tx_clock_out <= TX_IDLE; // see RL6
        o_uplink_rx_clock_oe <= !up_absent && i_mac_up_clk_drive;
      end
    end
  end

  // ******************************
  // checks
  // ******************************
  a_up_mii_upper: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !up_gmii |=> o_up_txd[7:4] == 4'h0 && !o_uplink_tx_error) // see RL6
    else $error("uplink mii upper tx not low");
  a_up_gmii_rxd: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(i_rst_n) && up_gmii && !up_absent
    |=> o_mac_up_rxd == $past(i_up_rxd)) // see RL5
    else $error("uplink gmii rx data wrong");
  a_up_txen_pass: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(i_rst_n) |=> o_up_txen == $past(i_mac_up_txen)) // see RL7
    else $error("uplink tx enable not passed");
  a_up_absent_idle: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    up_absent |=> !o_mac_up_crs && !o_mac_up_col && o_mac_up_rxdv) // see RL4
    else $error("uplink absent idle wrong");
  a_detect_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_detect_enabled |-> !up_absent) // see RL9
    else $error("absent while detection off");
  a_mode_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(i_rst_n) |=> o_uplink_gmii ==
    $past(i_uplink_interface_config != UPLINK_MODE_MII)) // see RL8
    else $error("uplink mode flag wrong");
  c_up_gmii: cover property (@(posedge i_clk_sys) up_gmii && !up_absent);
  c_up_mii: cover property (@(posedge i_clk_sys) !up_gmii && !up_absent);
  c_detect: cover property (@(posedge i_clk_sys) o_detect_enabled);
  c_absent: cover property (@(posedge i_clk_sys) up_absent);
endmodule // epm_pin_mux

/* verilog/epm_pkg.sv */
package epm_pkg;
  // ******************************
  // interface selection codes and counts
  // ******************************
  localparam logic [1:0] FAST_MODE_GPSI = 2'h0;
  localparam logic [1:0] FAST_MODE_MII = 2'h1;
  localparam logic [1:0] FAST_MODE_RMII = 2'h3;
  localparam logic [1:0] UPLINK_MODE_MII = 2'h0;
  localparam logic [1:0] UPLINK_MODE_GMII = 2'h3;
  localparam logic [1:0] FAST_MODE_RESET = FAST_MODE_MII;
  localparam logic [1:0] UPLINK_MODE_RESET = UPLINK_MODE_GMII;
  localparam int NUM_FAST_PORTS = 8;
  localparam int SYNC_STAGES = 3;
  localparam int STRAP_SETTLE_CYCLES = 4;

  // ******************************
  // pin idle levels
  // ******************************
  localparam logic PULL_UP = 1'h1;
  localparam logic PULL_DOWN = 1'h0;
  localparam logic TX_IDLE = 1'h0;
endpackage

/* verilog/epm_fast_port.sv */
`timescale 1ns/1ps
module epm_fast_port
  import epm_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [1:0] i_mode, // fast_port_interface_config
  input wire logic i_absent, // no module present
  input wire logic [3:0] i_rxd, // receive data pins
  input wire logic i_carrier_valid, // fast_port_carrier_valid pin
  input wire logic i_col, // collision pin
  input wire logic i_tx_clock, // fast_port_tx_clock pin in
  input wire logic i_rx_clock, // fast_port_rx_clock pin in
  input wire logic [3:0] i_mac_txd, // mac transmit data
  input wire logic i_mac_txen, // mac transmit enable
  input wire logic i_mac_tx_clock, // mac tx clock to drive
  input wire logic i_mac_rx_clock, // mac rx clock to drive
  input wire logic i_mac_clk_drive, // mac wants clocks driven
  output logic [3:0] o_txd, // transmit data pins
  output logic o_txen, // transmit enable pin
  output logic o_tx_clock, // tx clock out
  output logic o_tx_clock_oe, // tx clock output enable
  output logic o_rx_clock, // rx clock out
  output logic o_rx_clock_oe, // rx clock output enable
  output logic [3:0] o_mac_rxd, // receive data to mac
  output logic o_mac_crs_dv, // carrier or valid to mac
  output logic o_mac_col, // collision to mac
  output logic o_mac_tx_clock, // tx clock seen by mac
  output logic o_mac_rx_clock // rx clock seen by mac
);
  logic clk_mode;
  // only mii and gpsi use the clock pins; the undefined code keeps them low
  assign clk_mode = !i_absent &&
    (i_mode == FAST_MODE_MII || i_mode == FAST_MODE_GPSI); // see RL11

  // ******************************
  // receive side
  // ******************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mac_rxd <= {4{PULL_UP}};
      o_mac_crs_dv <= PULL_UP;
      o_mac_col <= PULL_DOWN;
      o_mac_tx_clock <= PULL_UP;
      o_mac_rx_clock <= PULL_UP;
    end else if (i_absent) begin
      o_mac_rxd <= {4{PULL_UP}}; // see RL4
      o_mac_crs_dv <= PULL_UP;
      o_mac_col <= PULL_DOWN;
      o_mac_tx_clock <= PULL_UP;
      o_mac_rx_clock <= PULL_UP;
    end else begin
      o_mac_crs_dv <= i_carrier_valid;
      case (i_mode)
        FAST_MODE_RMII: begin
          o_mac_rxd <= {{2{PULL_UP}}, i_rxd[1:0]}; // see RL1
          o_mac_col <= PULL_DOWN;
          o_mac_tx_clock <= PULL_UP;
          o_mac_rx_clock <= PULL_UP;
        end
        FAST_MODE_MII: begin
          o_mac_rxd <= i_rxd; // see RL2
          o_mac_col <= i_col;
          o_mac_tx_clock <= i_tx_clock;
          o_mac_rx_clock <= i_rx_clock;
        end
        FAST_MODE_GPSI: begin
          o_mac_rxd <= {{3{PULL_UP}}, i_rxd[0]}; // see RL3
          o_mac_col <= i_col;
          o_mac_tx_clock <= i_tx_clock;
          o_mac_rx_clock <= i_rx_clock;
        end
        default: begin
          o_mac_rxd <= {4{PULL_UP}};
          o_mac_col <= PULL_DOWN;
          o_mac_tx_clock <= PULL_UP;
          o_mac_rx_clock <= PULL_UP;
        end
      endcase
    end
  end

  // ******************************
  // transmit side
  // ******************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_txd <= {4{TX_IDLE}};
      o_txen <= TX_IDLE;
    end else begin
      o_txen <= i_mac_txen; // see RL4
      case (i_mode)
        FAST_MODE_RMII: o_txd <= {2'h0, i_mac_txd[1:0]}; // see RL11
        FAST_MODE_MII: o_txd <= i_mac_txd;
        FAST_MODE_GPSI: o_txd <= {3'h0, i_mac_txd[0]}; // see RL11
        default: o_txd <= {4{TX_IDLE}};
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_clock_oe <= 1'h0;
      o_rx_clock_oe <= 1'h0;
      o_tx_clock <= TX_IDLE;
      o_rx_clock <= TX_IDLE;
    end else begin
      o_tx_clock_oe <= clk_mode && i_mac_clk_drive; // see RL2
      o_rx_clock_oe <= clk_mode && i_mac_clk_drive;
      o_tx_clock <= clk_mode ? i_mac_tx_clock : TX_IDLE;
      o_rx_clock <= clk_mode ? i_mac_rx_clock : TX_IDLE;
    end
  end

  // ******************************
  // checks
  // ******************************
  a_rmii_col_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_mode == FAST_MODE_RMII |=> !o_mac_col) // see RL1
    else $error("rmii collision not held low");
  a_absent_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_absent |=> o_mac_rxd == 4'hf && o_mac_crs_dv && !o_mac_col) // see RL4
    else $error("absent port inputs not idle");
  a_gpsi_tx_pad: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_mode == FAST_MODE_GPSI |=> o_txd[3:1] == 3'h0) // see RL11
    else $error("gpsi unused txd not low");
  a_mii_rx_pass: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(i_rst_n) && !i_absent && i_mode == FAST_MODE_MII
    |=> o_mac_rxd == $past(i_rxd)) // see RL2
    else $error("mii rx data not passed");
  a_gpsi_rx_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(i_rst_n) && !i_absent && i_mode == FAST_MODE_GPSI
    |=> o_mac_rxd == {3'h7, $past(i_rxd[0])}) // see RL3
    else $error("gpsi rx bit wrong");
endmodule // epm_fast_port

/* verif/epm_phy_model.sv */
`timescale 1ns/1ps
// ******************************
// far-side phy for the fast ports
// ******************************
module epm_phy_model (
  input wire logic [7:0] i_present, // module fitted, per port
  input wire logic [31:0] i_rxd, // receive data the phy sends
  input wire logic [7:0] i_crs_dv, // carrier or valid the phy sends
  input wire logic [7:0] i_col, // collision the phy sends
  input wire logic [7:0] i_clk, // clock level the phy drives
  input wire logic [7:0] i_clk_drive, // phy drives both clock pins
  input wire logic [7:0] i_dev_tx_clock, // device tx clock out
  input wire logic [7:0] i_dev_tx_clock_oe, // device tx clock enable
  input wire logic [7:0] i_dev_rx_clock, // device rx clock out
  input wire logic [7:0] i_dev_rx_clock_oe, // device rx clock enable
  output logic [31:0] o_rxd, // receive data pins
  output logic [7:0] o_crs_dv, // carrier or valid pins
  output logic [7:0] o_col, // collision pins
  output logic [7:0] o_tx_clock, // resolved tx clock wires
  output logic [7:0] o_rx_clock // resolved rx clock wires
);
  logic [7:0] phy_clk_on;

  // an empty slot leaves every line to its pull resistor
  always_comb begin
    for (int g = 0; g < 8; g++) begin
      phy_clk_on[g] = i_present[g] & i_clk_drive[g];
      o_rxd[4*g+:4] = i_present[g] ? i_rxd[4*g+:4] : 4'hf;
      o_crs_dv[g] = i_present[g] ? i_crs_dv[g] : 1'h1;
      o_col[g] = i_present[g] & i_col[g];
      o_tx_clock[g] = i_dev_tx_clock_oe[g] ? i_dev_tx_clock[g] :
        (phy_clk_on[g] ? i_clk[g] : 1'h1);
      o_rx_clock[g] = i_dev_rx_clock_oe[g] ? i_dev_rx_clock[g] :
        (phy_clk_on[g] ? ~i_clk[g] : 1'h1);
    end
  end
endmodule // epm_phy_model

/* verif/epm_pin_mux_test.sv */
`timescale 1ns/1ps
module epm_pin_mux_test;
  import epm_pkg::*;
  logic i_clk_sys = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_module_detect_strap = 1'h0;
  logic i_uplink_module_present = 1'h1;
  logic [7:0] i_module_present = 8'hff;
  logic [15:0] i_fast_port_interface_config;
  logic [1:0] i_uplink_interface_config;
  logic [31:0] i_mac_fast_txd, phy_rxd, o_fast_txd, o_mac_fast_rxd;
  logic [7:0] i_mac_fast_txen, i_mac_fast_tx_clock, i_mac_fast_rx_clock;
  logic [7:0] i_mac_fast_clk_drive, phy_cv, phy_col, phy_clk, phy_drv;
  wire logic [31:0] i_fast_rxd;
  wire logic [7:0] i_fast_port_carrier_valid, i_fast_col;
  wire logic [7:0] i_fast_port_tx_clock, i_fast_port_rx_clock;
  logic [7:0] i_up_rxd, i_mac_up_txd, o_up_txd, o_mac_up_rxd;
  logic i_up_rxdv, i_uplink_rx_error, i_up_crs, i_up_col, up_rxc_phy;
  logic i_gigabit_reference_clock, i_uplink_mii_tx_clock_in;
  logic i_mac_up_txen, i_mac_up_txer, i_mac_up_gtx_clock;
  logic i_mac_up_rx_clock, i_mac_up_clk_drive;
  wire logic i_uplink_rx_clock;
  logic [7:0] o_fast_txen, o_fast_port_tx_clock, o_fast_port_tx_clock_oe;
  logic [7:0] o_fast_port_rx_clock, o_fast_port_rx_clock_oe;
  logic [7:0] o_mac_fast_crs_dv, o_mac_fast_col;
  logic [7:0] o_mac_fast_tx_clock, o_mac_fast_rx_clock;
  logic o_up_txen, o_uplink_tx_error, o_uplink_gmii_tx_clock_out;
  logic o_uplink_rx_clock, o_uplink_rx_clock_oe, o_mac_up_rxdv;
  logic o_mac_up_rxer, o_mac_up_crs, o_mac_up_col, o_mac_up_rx_clock;
  logic o_mac_up_ref_clock, o_mac_up_mii_tx_clock;
  logic o_detect_enabled, o_uplink_gmii;
  logic [31:0] seed = 32'h27;
  logic [31:0] e_txd, e_rxd;
  logic [7:0] e_oe, e_cv, e_col, e_tc, e_rc, pres_fix = 8'hff;
  logic [159:0] exp_q[$];
  logic chk = 1'h0;
  logic have = 1'h0;
  logic tog = 1'h0;
  logic det_on = 1'h0;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;

  always #4 i_clk_sys = ~i_clk_sys;
  // the uplink phy releases its rx clock while the device drives it
  assign i_uplink_rx_clock = o_uplink_rx_clock_oe ? o_uplink_rx_clock :
    up_rxc_phy;

  epm_pin_mux #(.NPORTS(8)) u_dut (.*);

  epm_phy_model u_phy (
    .i_present(i_module_present),
    .i_rxd(phy_rxd),
    .i_crs_dv(phy_cv),
    .i_col(phy_col),
    .i_clk(phy_clk),
    .i_clk_drive(phy_drv),
    .i_dev_tx_clock(o_fast_port_tx_clock),
    .i_dev_tx_clock_oe(o_fast_port_tx_clock_oe),
    .i_dev_rx_clock(o_fast_port_rx_clock),
    .i_dev_rx_clock_oe(o_fast_port_rx_clock_oe),
    .o_rxd(i_fast_rxd),
    .o_crs_dv(i_fast_port_carrier_valid),
    .o_col(i_fast_col),
    .o_tx_clock(i_fast_port_tx_clock),
    .o_rx_clock(i_fast_port_rx_clock)
  );

  // ******************************
  // stimulus and reference model
  // ******************************
  function automatic logic [31:0] rnd();
    repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic drive_rand();
    logic [31:0] r;
    phy_rxd <= rnd();
    i_mac_fast_txd <= rnd();
    {phy_cv, phy_col, phy_clk, phy_drv} <= rnd();
    {i_mac_fast_txen, i_mac_fast_tx_clock, i_mac_fast_rx_clock,
      i_mac_fast_clk_drive} <= rnd();
    r = rnd();
    // the undefined code 10 is driven too: it must idle the port's data, collision and clock lines
    i_fast_port_interface_config <= r[15:0];
    i_module_present <= tog ? r[23:16] : pres_fix;
    i_uplink_module_present <= tog ? r[24] : pres_fix[0];
    r = rnd();
    {i_up_rxd, i_mac_up_txd, i_up_rxdv, i_uplink_rx_error, i_up_crs,
      i_up_col, up_rxc_phy, i_gigabit_reference_clock,
      i_uplink_mii_tx_clock_in, i_mac_up_txen, i_mac_up_txer,
      i_mac_up_gtx_clock, i_mac_up_rx_clock, i_mac_up_clk_drive,
      i_uplink_interface_config} <= r[29:0];
  endtask

  task automatic predict();
    logic [1:0] m;
    logic ab;
    logic gm;
    logic ck;
    logic ua;
    for (int g = 0; g < 8; g++) begin
      m = i_fast_port_interface_config[2*g+:2];
      ab = det_on & ~i_module_present[g];
      ck = (m == FAST_MODE_MII) | (m == FAST_MODE_GPSI);
      e_txd[4*g+:4] = ck ? i_mac_fast_txd[4*g+:4] : 4'h0;
      e_rxd[4*g+:4] = ck ? i_fast_rxd[4*g+:4] : 4'hf;
      if (m == FAST_MODE_RMII) begin
        e_txd[4*g+:2] = i_mac_fast_txd[4*g+:2];
        e_rxd[4*g+:2] = i_fast_rxd[4*g+:2];
      end else if (m == FAST_MODE_GPSI) begin
        e_txd[4*g+1+:3] = 3'h0;
        e_rxd[4*g+1+:3] = 3'h7;
      end
      if (ab) e_rxd[4*g+:4] = 4'hf;
      e_oe[g] = ck & ~ab & i_mac_fast_clk_drive[g];
      e_cv[g] = ab | i_fast_port_carrier_valid[g];
      e_col[g] = ~ab & ck & i_fast_col[g];
      e_tc[g] = ab | ~ck | i_fast_port_tx_clock[g];
      e_rc[g] = ab | ~ck | i_fast_port_rx_clock[g];
    end
    exp_q.push_back({e_txd, i_mac_fast_txen, e_oe, e_oe,
      i_mac_fast_tx_clock & e_oe, i_mac_fast_rx_clock & e_oe, e_rxd,
      e_cv, e_col, e_tc, e_rc});
    ua = det_on & ~i_uplink_module_present;
    gm = i_uplink_interface_config != UPLINK_MODE_MII;
    exp_q.push_back({gm ? i_mac_up_txd : {4'h0, i_mac_up_txd[3:0]},
      i_mac_up_txen, gm & i_mac_up_txer, gm & i_mac_up_gtx_clock,
      ~gm & ~ua & i_mac_up_clk_drive,
      ~gm & ~ua & i_mac_up_clk_drive & i_mac_up_rx_clock,
      ua ? 8'hff : gm ? i_up_rxd : {4'hf, i_up_rxd[3:0]}, ua | i_up_rxdv,
      ua | (gm & i_uplink_rx_error), ~ua & i_up_crs, ~ua & i_up_col,
      ua | i_uplink_rx_clock, ua | i_gigabit_reference_clock,
      ua | i_uplink_mii_tx_clock_in, gm});
  endtask

  task automatic check(input logic [159:0] act, input logic [159:0] exp);
    tests_run++;
    if (act !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    drive_rand();
    have <= chk;
    if (chk) predict();
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  always @(negedge i_clk_sys) begin
    if (have) begin
      check({o_fast_txd, o_fast_txen, o_fast_port_tx_clock_oe,
        o_fast_port_rx_clock_oe, o_fast_port_tx_clock & o_fast_port_tx_clock_oe,
        o_fast_port_rx_clock & o_fast_port_rx_clock_oe, o_mac_fast_rxd,
        o_mac_fast_crs_dv, o_mac_fast_col, o_mac_fast_tx_clock,
        o_mac_fast_rx_clock},
        exp_q.pop_front());
      check({o_up_txd, o_up_txen, o_uplink_tx_error,
        o_uplink_gmii_tx_clock_out, o_uplink_rx_clock_oe,
        o_uplink_rx_clock & o_uplink_rx_clock_oe, o_mac_up_rxd,
        o_mac_up_rxdv, o_mac_up_rxer, o_mac_up_crs, o_mac_up_col,
        o_mac_up_rx_clock, o_mac_up_ref_clock, o_mac_up_mii_tx_clock,
        o_uplink_gmii}, exp_q.pop_front());
    end
  end

  // ******************************
  // scenarios
  // ******************************
  task automatic do_reset(input logic s);
    chk <= 1'h0;
    @(posedge i_clk_sys);
    i_module_detect_strap <= s;
    i_rst_n <= 1'h0;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check({o_fast_txd, o_fast_txen, o_fast_port_tx_clock_oe, o_up_txd,
      o_mac_fast_rxd}, {32'h0, 8'h0, 8'h0, 8'h0, 32'hffffffff});
    @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    repeat (10) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    det_on = s;
    check(o_detect_enabled, s);
    @(posedge i_clk_sys);
    chk <= 1'h1;
  endtask

  initial begin
    drive_rand();
    // detection off: presence is random every cycle yet no port idles
    tog = 1'h1;
    do_reset(1'h0);
    repeat (300) @(posedge i_clk_sys);
    tog <= 1'h0;
    do_reset(1'h1);
    repeat (300) @(posedge i_clk_sys);
    foreach (pres_fix[k]) begin
      if (k < 2) begin
        chk <= 1'h0;
        pres_fix <= (k == 0) ? 8'h5a : 8'h00;
        repeat (8) @(posedge i_clk_sys);
        chk <= 1'h1;
        repeat (200) @(posedge i_clk_sys);
      end
    end
    chk <= 1'h0;
    repeat (2) @(posedge i_clk_sys);
    report_and_stop();
  end
endmodule // epm_pin_mux_test
